// file: common/wbf_pkg.sv
// Purpose: Constants and carrier types for the word-to-byte bus funnel
// Assumes: Single 100 MHz clock, asynchronous active-low reset
// Notes:   Functional notes follow
package wbf_pkg;
    localparam int unsigned BYTE_W    = 8;
    localparam int unsigned WORD_W    = 16;
    localparam logic        SEL_LOW   = 1'b0;
    localparam logic        SEL_HIGH  = 1'b1;
    localparam logic        DIR_READ  = 1'b1;
    localparam logic        DIR_WRITE = 1'b0;

    typedef enum logic [2:0] {
        WBF_IDLE   = 3'h0,
        WBF_MR_LO  = 3'h1,
        WBF_MR_GAP = 3'h3,
        WBF_MR_HI  = 3'h2,
        WBF_MR_END = 3'h6,
        WBF_SL_ACT = 3'h4,
        WBF_SL_END = 3'h5
    } wbf_state_t;

    // Processor-side bus signals (active-low strobes inverted to active high)
    typedef struct packed {
        logic rd;
        logic wr;
        logic sel;
        logic cs;
        logic mem_ack;
        logic grant;
    } wbf_cpu_t;

    // Peripheral-side mastering signals
    typedef struct packed {
        logic as;
        logic ds;
        logic rw;
        logic breq;
    } wbf_per_t;

    // Data-path controls for the bidirectional latch port and transceiver
    typedef struct packed {
        logic up_clk;
        logic up_oe_in;
        logic up_oe_out;
        logic xcv_oe;
    } wbf_path_t;
endpackage : wbf_pkg

// file: src/wbf_funnel.sv
// Purpose: Control state machine funnelling a 16-bit peripheral onto an 8-bit bus
// Assumes: Strobes arrive from pins and are synchronised; data path is external
// Notes:   Upper byte lane is latched; lower lane passes straight
`timescale 1ns/1ps
`default_nettype none
module wbf_funnel (
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_n,
    input  wire wbf_pkg::wbf_cpu_t i_cpu,
    input  wire wbf_pkg::wbf_per_t i_per,
    output var  logic              o_byte_select,
    output var  logic              o_sys_rd,
    output var  logic              o_sys_wr,
    output var  logic              o_per_hold,
    output var  logic              o_peripheral_data_strobe,
    output var  logic              o_per_dir,
    output var  logic              o_per_ctl_oe_n,
    output var  logic              o_bus_lock,
    output var  wbf_pkg::wbf_path_t o_path
);
    import wbf_pkg::*;

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    localparam int unsigned NSYNC = 10;

    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn_in;
    wbf_cpu_t         cpu_s;
    wbf_per_t         per_s;

    assign raw_in = {i_cpu, i_per};

    wbf_sync #(
        .WIDTH (NSYNC)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_async   (raw_in),
        .o_sync    (syn_in)
    );

    assign cpu_s = syn_in[NSYNC-1:4];
    assign per_s = syn_in[3:0];

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        wbf_state_t state;
        logic       master;
        logic       byte_select;
        logic       sys_rd;
        logic       per_hold;
        logic       pds;
        logic       per_dir;
        logic       ctl_oe_n;
        logic       lock;
        logic       half_done;
        logic       rd_q;
        logic       wr_q;
        wbf_path_t  path;
    } wbf_st_t;

    wbf_st_t st_reg;
    wbf_st_t st_next;

    logic cpu_rd_rise;
    logic cpu_wr_rise;
    logic cpu_rd_fall;
    logic cpu_wr_fall;
    logic per_rd_req;

    assign cpu_rd_rise = cpu_s.rd & ~st_reg.rd_q;
    assign cpu_wr_rise = cpu_s.wr & ~st_reg.wr_q;
    assign cpu_rd_fall = ~cpu_s.rd & st_reg.rd_q;
    assign cpu_wr_fall = ~cpu_s.wr & st_reg.wr_q;
    // Direction low with strobe is an address-latch update only
    assign per_rd_req  = per_s.as & per_s.ds & (per_s.rw == DIR_READ);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_next             = st_reg;
        st_next.rd_q        = cpu_s.rd;
        st_next.wr_q        = cpu_s.wr;
        st_next.path.up_clk = 1'b0;
        o_sys_wr            = 1'b0;
        case (st_reg.state)
            WBF_IDLE: begin
                st_next.master   = 1'b0;
                st_next.per_hold = 1'b0;
                st_next.sys_rd   = 1'b0;
                st_next.path     = '0;
                st_next.ctl_oe_n = 1'b0;
                // Processor byte select passes through in slave mode
                st_next.byte_select = cpu_s.sel;
                st_next.pds      = 1'b0;
                st_next.per_dir  = DIR_READ;
                // Wait for the previous transfer's acknowledge to clear
                if (!cpu_s.mem_ack) begin
                    // Arbitration picks master or slave sequence
                    // A half-done slave word keeps the bus locked against masters
                    if (cpu_s.grant && per_s.breq && per_rd_req && !st_reg.lock) begin
                        st_next.master      = 1'b1;
                        st_next.ctl_oe_n    = 1'b1;
                        st_next.per_hold    = 1'b1;
                        st_next.byte_select = SEL_HIGH;
                        st_next.sys_rd      = 1'b1;
                        st_next.path.up_oe_in = 1'b1;
                        st_next.state       = WBF_MR_LO;
                    end else if (cpu_s.cs && !cpu_s.grant && (cpu_rd_rise || cpu_wr_rise)) begin
                        st_next.state     = WBF_SL_ACT;
                        st_next.half_done = 1'b0;
                        st_next.lock      = 1'b1;
                        if (cpu_rd_rise) begin
                            // Upper byte from the latch, lower via transceiver
                            st_next.per_dir = DIR_READ;
                            st_next.pds     = ~st_reg.half_done;
                            st_next.path.up_oe_out = (cpu_s.sel == SEL_HIGH);
                            st_next.path.xcv_oe    = (cpu_s.sel == SEL_LOW);
                        end else begin
                            st_next.per_dir = DIR_WRITE;
                            if (cpu_s.sel == SEL_HIGH) begin
                                st_next.path.up_clk = 1'b1;
                            end else begin
                                // Lower or pointer byte goes straight in
                                st_next.pds         = 1'b1;
                                st_next.path.xcv_oe = 1'b1;
                                st_next.path.up_oe_in = 1'b1;
                            end
                        end
                    end
                end
            end
            WBF_MR_LO: begin
                if (cpu_s.mem_ack) begin
                    // Capture the first byte in the upper latch
                    st_next.path.up_clk = 1'b1;
                    st_next.sys_rd      = 1'b0;
                    st_next.state       = WBF_MR_GAP;
                end
            end
            WBF_MR_GAP: begin
                if (!cpu_s.mem_ack) begin
                    st_next.byte_select = SEL_LOW;
                    st_next.sys_rd      = 1'b1;
                    st_next.state       = WBF_MR_HI;
                end
            end
            WBF_MR_HI: begin
                if (cpu_s.mem_ack) begin
                    // Second byte loads directly with latched byte
                    st_next.per_hold  = 1'b0;
                    st_next.path.xcv_oe = 1'b1;
                    st_next.state     = WBF_MR_END;
                end
            end
            WBF_MR_END: begin
                if (!per_s.ds) begin
                    st_next.sys_rd = 1'b0;
                    st_next.path   = '0;
                    st_next.master = 1'b0;
                    st_next.ctl_oe_n = 1'b0;
                    st_next.state  = WBF_IDLE;
                end
            end
            WBF_SL_ACT: begin
                st_next.byte_select = cpu_s.sel;
                if (cpu_rd_fall || cpu_wr_fall) begin
                    st_next.path.up_oe_out = 1'b0;
                    st_next.path.xcv_oe    = 1'b0;
                    st_next.path.up_oe_in  = 1'b0;
                    st_next.pds            = 1'b0;
                    st_next.state          = WBF_SL_END;
                end
            end
            WBF_SL_END: begin
                // Word completes on the lower-lane access; pointer writes are single
                if (st_reg.byte_select == SEL_LOW) begin
                    st_next.half_done = 1'b0;
                    st_next.lock      = 1'b0;
                end else begin
                    st_next.half_done = 1'b1;
                end
                st_next.state = WBF_IDLE;
            end
            default: begin
                st_next.state = WBF_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg         <= '0;
            st_reg.state   <= WBF_IDLE;
            st_reg.per_dir <= DIR_READ;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_byte_select            = st_reg.byte_select;
    assign o_sys_rd                 = st_reg.sys_rd;
    assign o_per_hold               = st_reg.per_hold;
    assign o_peripheral_data_strobe = st_reg.pds;
    assign o_per_dir                = st_reg.per_dir;
    assign o_per_ctl_oe_n           = st_reg.ctl_oe_n;
    assign o_bus_lock               = st_reg.lock;
    assign o_path                   = st_reg.path;
endmodule : wbf_funnel
`default_nettype wire

// file: src/wbf_sync.sv
// Purpose: Two-flop synchroniser for a bundle of pin inputs
// Assumes: Inputs asynchronous to i_ref_clk
// Notes:   First stage read only by second stage
`timescale 1ns/1ps
`default_nettype none
module wbf_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output var  logic [WIDTH-1:0] o_sync
);
    import wbf_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } wbf_sync_st_t;

    wbf_sync_st_t st_reg;
    wbf_sync_st_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.meta = i_async;
        st_next.sync = st_reg.meta;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_sync = st_reg.sync;
endmodule : wbf_sync
`default_nettype wire

// file: tb/tb.sv
// Purpose: Self-checking bench for the funnel
// Assumes: Memory model on the narrow bus
// Notes:   Seeded random mix of transfers
`timescale 1ns/1ps
`default_nettype none
module tb;
    import wbf_pkg::*;
    logic      i_ref_clk, i_rst_n, ack_force, mem_ack;
    logic      o_byte_select, o_sys_rd, o_sys_wr, o_per_hold, o_peripheral_data_strobe;
    logic      o_per_dir, o_per_ctl_oe_n, o_bus_lock;
    wbf_cpu_t  i_cpu;
    wbf_per_t  i_per;
    wbf_path_t o_path;
    int        errors, num_checks, cycles, ack_wait;
    bit        b;
    wbf_funnel i_wbf_funnel (.i_ref_clk, .i_rst_n, .i_cpu, .i_per, .o_byte_select, .o_sys_rd,
        .o_sys_wr, .o_per_hold, .o_peripheral_data_strobe, .o_per_dir, .o_per_ctl_oe_n,
        .o_bus_lock, .o_path);
    wbf_mem_model i_wbf_mem_model (.i_ref_clk, .i_rst_n, .i_sys_rd(o_sys_rd),
        .i_wait(ack_wait[2:0]), .o_mem_ack(mem_ack));
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            final_report();
        end
        #1 i_cpu.mem_ack = mem_ack | ack_force;
    end
    task automatic final_report();
        if (errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : step
    function automatic logic exp_ds(input bit rd, input bit sel);
        return rd == sel;
    endfunction : exp_ds
    // Master read, optionally with acknowledge stuck high at the request
    task automatic mread(input int w, input bit pre);
        int   n;
        int   rises;
        logic prev;
        logic [1:0] sels;
        ack_wait = w;
        ack_force = pre;
        if (pre) step(2);
        i_cpu.grant = 1'b1;
        i_per = 4'hf;
        if (pre) begin
            step(12);
            chk("hold_ack", o_per_hold, 8'h0);
            ack_force = 1'b0;
        end
        n = 0;
        while (!o_per_hold && n < 20) begin
            step(1);
            n++;
        end
        chk("hold_up", o_per_hold, 8'h1);
        chk("ctl_oe_n", o_per_ctl_oe_n, 8'h1);
        i_cpu.cs = 1'b1;
        i_cpu.rd = 1'b1;
        rises = 0;
        prev = 1'b0;
        sels = 2'h0;
        while (o_per_hold && n < 200) begin
            if (o_sys_rd && !prev) begin
                sels = {sels[0], o_byte_select};
                rises++;
            end
            chk("slave_in_master", o_peripheral_data_strobe, 8'h0);
            prev = o_sys_rd;
            step(1);
            n++;
        end
        chk("rd_count", 8'(rises), 8'h2);
        chk("sel_order", {6'h0, sels}, 8'h2);
        chk("xcv_lower", o_path.xcv_oe, 8'h1);
        chk("load_in", o_path.up_oe_in, 8'h1);
        chk("sys_wr", o_sys_wr, 8'h0);
        i_cpu.cs = 1'b0;
        i_cpu.rd = 1'b0;
        i_per = 4'h0;
        i_cpu.grant = 1'b0;
        step(8);
        chk("idle", {5'h0, o_per_hold, o_sys_rd, o_path.xcv_oe}, 8'h0);
    endtask : mread
    // Processor byte access to the funnel
    task automatic sacc(input bit rd, input bit sel);
        int ds_n;
        int clk_n;
        int oe_n;
        i_cpu.cs = 1'b1;
        i_cpu.sel = sel;
        step(4);
        i_cpu.rd = rd;
        i_cpu.wr = !rd;
        ds_n = 0;
        clk_n = 0;
        oe_n = 0;
        for (int i = 0; i < 16; i++) begin
            step(1);
            if (i == 9) {i_cpu.rd, i_cpu.wr} = 2'b00;
            ds_n += int'(o_peripheral_data_strobe);
            clk_n += int'(o_path.up_clk);
            oe_n += int'(o_path.up_oe_out);
        end
        chk("ds_once", 8'(ds_n != 0), {7'h0, exp_ds(rd, sel)});
        if (!rd) chk("up_latch", 8'(clk_n), {7'h0, sel});
        else chk("up_out", 8'(oe_n != 0), {7'h0, sel});
        chk("lock", o_bus_lock, {7'h0, sel});
        i_cpu.cs = 1'b0;
        step(2);
    endtask : sacc
    initial begin
        errors = 0;
        num_checks = 0;
        cycles = 0;
        ack_force = 1'b0;
        ack_wait = 0;
        i_cpu = '0;
        i_per = '0;
        i_rst_n = 1'b0;
        void'($urandom(32'h7fed));
        step(5);
        i_rst_n = 1'b1;
        step(3);
        mread(0, 1'b1);
        mread(4, 1'b0);
        i_cpu.grant = 1'b1;
        i_per = 4'hd;
        step(12);
        chk("rw_low", o_per_hold, 8'h0);
        i_per = 4'h0;
        i_cpu.grant = 1'b0;
        step(4);
        for (int k = 0; k < 4; k++) sacc(k[1], !k[0]);
        sacc(1'b0, 1'b0);
        sacc(1'b1, 1'b1);
        i_cpu.grant = 1'b1;
        i_per = 4'hf;
        step(8);
        chk("lock_master", o_per_hold, 8'h0);
        i_per = 4'h0;
        i_cpu.grant = 1'b0;
        step(4);
        sacc(1'b1, 1'b0);
        repeat (8) begin
            b = 1'($urandom_range(0, 1));
            if ($urandom_range(0, 1)) mread($urandom_range(0, 4), 1'b0);
            else begin
                sacc(b, 1'b1);
                sacc(b, 1'b0);
            end
        end
        i_cpu.grant = 1'b1;
        i_per = 4'hf;
        step(6);
        i_rst_n = 1'b0;
        step(1);
        chk("rst_mid", {6'h0, o_per_hold, o_per_dir}, 8'h1);
        i_per = 4'h0;
        i_cpu.grant = 1'b0;
        i_rst_n = 1'b1;
        step(4);
        mread(1, 1'b0);
        final_report();
    end
endmodule : tb
bind wbf_funnel wbf_funnel_properties i_wbf_funnel_properties (.i_ref_clk, .i_rst_n, .i_cpu,
    .i_per, .o_byte_select, .o_sys_rd, .o_sys_wr, .o_per_hold, .o_peripheral_data_strobe,
    .o_per_dir, .o_per_ctl_oe_n, .o_bus_lock, .o_path);
`default_nettype wire

// file: tb/wbf_funnel_properties.sv
// Purpose: Port assertions for the funnel
// Assumes: Bench holds requests stable
// Notes:   Bound from tb
`timescale 1ns/1ps
`default_nettype none
module wbf_funnel_properties (
    input wire logic               i_ref_clk,
    input wire logic               i_rst_n,
    input wire wbf_pkg::wbf_cpu_t  i_cpu,
    input wire wbf_pkg::wbf_per_t  i_per,
    input wire logic               o_byte_select,
    input wire logic               o_sys_rd,
    input wire logic               o_sys_wr,
    input wire logic               o_per_hold,
    input wire logic               o_peripheral_data_strobe,
    input wire logic               o_per_dir,
    input wire logic               o_per_ctl_oe_n,
    input wire logic               o_bus_lock,
    input wire wbf_pkg::wbf_path_t o_path
);
    import wbf_pkg::*;
    logic [2:0] rd_cnt_reg;
    logic       rd_q_reg;
    // Counts read strobes within one hold period
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_cnt_reg <= 3'h0;
            rd_q_reg   <= 1'b0;
        end else begin
            rd_q_reg   <= o_sys_rd;
            rd_cnt_reg <= !o_per_hold ? 3'h0 : rd_cnt_reg + {2'h0, o_sys_rd & ~rd_q_reg};
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    AST_NO_SYS_WR: assert property (o_sys_wr == 1'b0)
        else $error("system write strobe driven");
    AST_RD_UNDER_HOLD: assert property (o_sys_rd && !o_path.xcv_oe |-> o_per_hold)
        else $error("read strobe without hold");
    AST_UPPER_FIRST: assert property ($rose(o_per_hold) |-> o_byte_select && o_sys_rd)
        else $error("master read not starting on upper byte");
    AST_TWO_READS: assert property ($fell(o_per_hold) |-> rd_cnt_reg == 3'h2)
        else $error("read strobe count per word wrong");
    AST_ACK_IDLE: assert property ($rose(o_per_hold) |-> !$past(i_cpu.mem_ack, 3))
        else $error("start while acknowledge active");
    AST_RW_GRANT: assert property ($rose(o_per_hold) |->
        $past(i_per.rw, 3) && $past(i_cpu.grant, 3))
        else $error("start without read or grant");
    AST_LATCH_PULSE: assert property (o_path.up_clk |=> !o_path.up_clk)
        else $error("latch clock longer than one cycle");
    AST_MASTER_PINS: assert property (o_per_hold |-> o_per_ctl_oe_n)
        else $error("strobe pins driven while mastering");
    AST_NO_MIX: assert property (o_peripheral_data_strobe |-> !o_per_hold)
        else $error("slave strobe inside master word");
    AST_SEL_PASS: assert property ($rose(o_peripheral_data_strobe) |->
        o_byte_select == i_cpu.sel && o_per_dir == i_cpu.rd)
        else $error("slave select or direction wrong");
    AST_XCV_LOWER: assert property (o_path.xcv_oe && o_per_ctl_oe_n |-> !o_byte_select)
        else $error("transceiver on upper lane");
    AST_LOCK_NO_MASTER: assert property ($rose(o_per_hold) |-> !$past(o_bus_lock))
        else $error("master start inside slave word");
endmodule : wbf_funnel_properties
`default_nettype wire

// file: tb/wbf_mem_model.sv
// Purpose: Narrow bus memory answering read strobes
// Assumes: One strobe per byte cycle
// Notes:   Wait count set by bench
`timescale 1ns/1ps
`default_nettype none
module wbf_mem_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_sys_rd,
    input  wire logic [2:0] i_wait,
    output var  logic       o_mem_ack
);
    logic [2:0] cnt_reg;
    // Acknowledge after i_wait cycles, drop once the strobe goes
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n || !i_sys_rd) begin
            cnt_reg   <= 3'h0;
            o_mem_ack <= 1'b0;
        end else if (cnt_reg >= i_wait) begin
            o_mem_ack <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 3'h1;
        end
    end
endmodule : wbf_mem_model
`default_nettype wire
